// *** verilog/scan_id_map.svh ***
// Purpose: constants for the scan identification, signature and clamp path
// Assumes: four-bit instruction register, 32-bit identification register
// Notes:   instruction codes and identity value are local choices
//
// Contract
// - identification instruction captures the fixed 32-bit identity code into identity register
// - identification instruction routes identity register between serial in and serial out
// - signature instruction also routes identity register between serial in and out
// - signature instruction loads identity register from 32-bit user code, then shifts
// - user code reads a default value until configuration completes
// - clamp instruction drives pins from values held in boundary register
// - clamp instruction selects one-bit bypass register as serial path
`ifndef SCAN_ID_MAP_SVH
`define SCAN_ID_MAP_SVH

`define IR_LEN            4
`define IR_CAPTURE        4'h1
`define IR_SAMPLE         4'h5
`define IR_IDCODE         4'h6
`define IR_USERCODE       4'h7
`define IR_CLAMP          4'hA
`define IR_BYPASS         4'hF
`define ID_LEN            32
// identity value is arbitrary; bit 0 set as the scan standard requires
`define ID_VALUE          32'h0A5C_3E01
`define USER_CODE_DEFAULT 32'hFFFF_FFFF
`define BSR_LEN           8

`endif

// *** verilog/scan_id_pkg.sv ***
// Purpose: types shared by the scan path modules
// Assumes: nothing
// Notes:   none
`default_nettype none
package scan_id_pkg;
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_e;
endpackage
`default_nettype wire

// *** verilog/tap_sequencer.sv ***
// Purpose: test access port state sequencer on the test clock
// Assumes: reset is already synchronous to the test clock
// Notes:   five test clocks with mode select high also reach reset state
`timescale 1ns/10ps
`default_nettype none
module tap_sequencer (
  // clock and reset
  input  wire logic                     i_tck,
  input  wire logic                     i_rst,
  // mode select
  input  wire logic                     i_tms,
  // state
  output scan_id_pkg::tap_state_e       o_state
);
  scan_id_pkg::tap_state_e state;
  scan_id_pkg::tap_state_e next_state;

  always_comb begin
    case (state)
      scan_id_pkg::ST_TLR:    next_state = i_tms ? scan_id_pkg::ST_TLR    : scan_id_pkg::ST_RTI;
      scan_id_pkg::ST_RTI:    next_state = i_tms ? scan_id_pkg::ST_SEL_DR : scan_id_pkg::ST_RTI;
      scan_id_pkg::ST_SEL_DR: next_state = i_tms ? scan_id_pkg::ST_SEL_IR : scan_id_pkg::ST_CAP_DR;
      scan_id_pkg::ST_CAP_DR: next_state = i_tms ? scan_id_pkg::ST_EX1_DR : scan_id_pkg::ST_SH_DR;
      scan_id_pkg::ST_SH_DR:  next_state = i_tms ? scan_id_pkg::ST_EX1_DR : scan_id_pkg::ST_SH_DR;
      scan_id_pkg::ST_EX1_DR: next_state = i_tms ? scan_id_pkg::ST_UPD_DR : scan_id_pkg::ST_PAU_DR;
      scan_id_pkg::ST_PAU_DR: next_state = i_tms ? scan_id_pkg::ST_EX2_DR : scan_id_pkg::ST_PAU_DR;
      scan_id_pkg::ST_EX2_DR: next_state = i_tms ? scan_id_pkg::ST_UPD_DR : scan_id_pkg::ST_SH_DR;
      scan_id_pkg::ST_UPD_DR: next_state = i_tms ? scan_id_pkg::ST_SEL_DR : scan_id_pkg::ST_RTI;
      scan_id_pkg::ST_SEL_IR: next_state = i_tms ? scan_id_pkg::ST_TLR    : scan_id_pkg::ST_CAP_IR;
      scan_id_pkg::ST_CAP_IR: next_state = i_tms ? scan_id_pkg::ST_EX1_IR : scan_id_pkg::ST_SH_IR;
      scan_id_pkg::ST_SH_IR:  next_state = i_tms ? scan_id_pkg::ST_EX1_IR : scan_id_pkg::ST_SH_IR;
      scan_id_pkg::ST_EX1_IR: next_state = i_tms ? scan_id_pkg::ST_UPD_IR : scan_id_pkg::ST_PAU_IR;
      scan_id_pkg::ST_PAU_IR: next_state = i_tms ? scan_id_pkg::ST_EX2_IR : scan_id_pkg::ST_PAU_IR;
      scan_id_pkg::ST_EX2_IR: next_state = i_tms ? scan_id_pkg::ST_UPD_IR : scan_id_pkg::ST_SH_IR;
      scan_id_pkg::ST_UPD_IR: next_state = i_tms ? scan_id_pkg::ST_SEL_DR : scan_id_pkg::ST_RTI;
      default:                next_state = scan_id_pkg::ST_TLR;
    endcase
  end

  always_ff @(posedge i_tck) begin
    if (i_rst) begin
      state <= scan_id_pkg::ST_TLR;
    end else begin
      state <= next_state;
    end
  end

  assign o_state = state;
endmodule // tap_sequencer
`default_nettype wire

// *** verilog/scan_id_path.sv ***
// Purpose: instruction-steered data registers: identity, user signature, bypass, boundary clamp
// Assumes: user code and configuration flag come from logic on i_mclk
// Notes:   test logic runs on i_tck; serial out changes on the falling test clock edge
`include "scan_id_map.svh"
`timescale 1ns/10ps
`default_nettype none
module scan_id_path (
  // system clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_sys_rst,
  // scan link
  input  wire logic                  i_tck,
  input  wire logic                  i_tms,
  input  wire logic                  i_tdi,
  output logic                       o_tdo,
  output logic                       o_tdo_oe,
  // configuration
  input  wire logic                  i_config_done,
  input  wire logic [`ID_LEN-1:0]    i_user_code,
  // pins
  input  wire logic [`BSR_LEN-1:0]   i_core_out,
  input  wire logic [`BSR_LEN-1:0]   i_pin_in,
  output logic      [`BSR_LEN-1:0]   o_pin_out
);
  ////////////////////////////////////////////////////////////////////////////
  // system domain: user signature register and pin drive
  logic                  configured;
  logic [`ID_LEN-1:0]    user_code;
  logic                  clamp_m1;
  logic                  clamp_m2;
  logic                  next_configured;
  logic [`ID_LEN-1:0]    next_user_code;
  logic [`BSR_LEN-1:0]   next_pin_out;
  logic [`BSR_LEN-1:0]   bsr_hold;
  logic                  clamp_on;

  always_comb begin
    next_configured = configured | i_config_done;
    // the signature is frozen once configured so the scan side can read it as static
    next_user_code  = (i_config_done && !configured) ? i_user_code : user_code;
    next_pin_out    = clamp_m2 ? bsr_hold : i_core_out;
  end

  always_ff @(posedge i_mclk) begin
    clamp_m1 <= clamp_on;
    clamp_m2 <= clamp_m1;
    if (i_sys_rst) begin
      configured <= 1'b0;
      user_code  <= `USER_CODE_DEFAULT;
      o_pin_out  <= '0;
    end else begin
      configured <= next_configured;
      user_code  <= next_user_code;
      o_pin_out  <= next_pin_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test clock domain
  logic                  rst_t1;
  logic                  rst_t2;
  logic                  cfg_t1;
  logic                  cfg_t2;
  logic [`BSR_LEN-1:0]   pin_t1;
  logic [`BSR_LEN-1:0]   pin_t2;
  scan_id_pkg::tap_state_e state;

  always_ff @(posedge i_tck) begin
    rst_t1 <= i_sys_rst;
    rst_t2 <= rst_t1;
    cfg_t1 <= configured;
    cfg_t2 <= cfg_t1;
    pin_t1 <= i_pin_in;
    pin_t2 <= pin_t1;
  end

  tap_sequencer u_tap (
    .i_tck   (i_tck),
    .i_rst   (rst_t2),
    .i_tms   (i_tms),
    .o_state (state)
  );

  logic [`IR_LEN-1:0]    ir_shift;
  logic [`IR_LEN-1:0]    ir;
  logic [`ID_LEN-1:0]    id_reg;
  logic                  bypass;
  logic [`BSR_LEN-1:0]   bsr_shift;
  logic [`BSR_LEN-1:0]   bsr_upd;
  logic [`IR_LEN-1:0]    next_ir_shift;
  logic [`IR_LEN-1:0]    next_ir;
  logic [`ID_LEN-1:0]    next_id_reg;
  logic                  next_bypass;
  logic [`BSR_LEN-1:0]   next_bsr_shift;
  logic [`BSR_LEN-1:0]   next_bsr_upd;
  logic                  next_tdo;
  logic                  cap_dr;
  logic                  sh_dr;
  logic                  id_sel;
  logic                  bsr_sel;

  assign cap_dr  = (state == scan_id_pkg::ST_CAP_DR);
  assign sh_dr   = (state == scan_id_pkg::ST_SH_DR);
  assign id_sel  = (ir == `IR_IDCODE) || (ir == `IR_USERCODE);
  assign bsr_sel = (ir == `IR_SAMPLE);
  assign clamp_on = (ir == `IR_CLAMP);
  assign bsr_hold = bsr_upd;

  always_comb begin
    next_ir_shift  = ir_shift;
    next_ir        = ir;
    next_id_reg    = id_reg;
    next_bypass    = bypass;
    next_bsr_shift = bsr_shift;
    next_bsr_upd   = bsr_upd;
    case (state)
      scan_id_pkg::ST_TLR:    next_ir = `IR_IDCODE;
      scan_id_pkg::ST_CAP_IR: next_ir_shift = `IR_CAPTURE;
      scan_id_pkg::ST_SH_IR:  next_ir_shift = {i_tdi, ir_shift[`IR_LEN-1:1]};
      scan_id_pkg::ST_UPD_IR: next_ir = ir_shift;
      scan_id_pkg::ST_CAP_DR: begin
        next_bypass = 1'b0;
        if (ir == `IR_IDCODE) begin
          next_id_reg = `ID_VALUE;
        end else if (ir == `IR_USERCODE) begin
          // default until the system side reports configuration done
          next_id_reg = cfg_t2 ? user_code : `USER_CODE_DEFAULT;
        end
        if (bsr_sel) begin
          next_bsr_shift = pin_t2;
        end
      end
      scan_id_pkg::ST_SH_DR: begin
        next_bypass = i_tdi;
        if (id_sel) begin
          next_id_reg = {i_tdi, id_reg[`ID_LEN-1:1]};
        end
        if (bsr_sel) begin
          next_bsr_shift = {i_tdi, bsr_shift[`BSR_LEN-1:1]};
        end
      end
      // clamp leaves the update stage untouched so the pins hold steady
      scan_id_pkg::ST_UPD_DR: if (bsr_sel) next_bsr_upd = bsr_shift;
      default: ;
    endcase
    if (state == scan_id_pkg::ST_SH_IR) begin
      next_tdo = ir_shift[0];
    end else if (id_sel) begin
      next_tdo = id_reg[0];
    end else if (bsr_sel) begin
      next_tdo = bsr_shift[0];
    end else begin
      next_tdo = bypass;
    end
  end

  always_ff @(posedge i_tck) begin
    if (rst_t2) begin
      ir_shift  <= `IR_CAPTURE;
      ir        <= `IR_IDCODE;
      id_reg    <= '0;
      bypass    <= 1'b0;
      bsr_shift <= '0;
      bsr_upd   <= '0;
    end else begin
      ir_shift  <= next_ir_shift;
      ir        <= next_ir;
      id_reg    <= next_id_reg;
      bypass    <= next_bypass;
      bsr_shift <= next_bsr_shift;
      bsr_upd   <= next_bsr_upd;
    end
  end

  // falling edge launch gives the controller a half period of hold
  always_ff @(negedge i_tck) begin
    if (rst_t2) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      o_tdo    <= next_tdo;
      o_tdo_oe <= sh_dr || (state == scan_id_pkg::ST_SH_IR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_id_cap;
    @(posedge i_tck) disable iff (rst_t2) cap_dr && ir == `IR_IDCODE |=> id_reg == `ID_VALUE;
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("identity code not captured");

  property p_id_path;
    @(posedge i_tck) disable iff (rst_t2) sh_dr && ir == `IR_IDCODE |-> o_tdo == id_reg[0];
  endproperty
  a_id_path: assert property (p_id_path) else $error("identity register not on serial path");

  property p_user_path;
    @(posedge i_tck) disable iff (rst_t2) sh_dr && ir == `IR_USERCODE |-> o_tdo == id_reg[0];
  endproperty
  a_user_path: assert property (p_user_path) else $error("signature not on serial path");

  property p_user_cap;
    @(posedge i_tck) disable iff (rst_t2) cap_dr && ir == `IR_USERCODE && cfg_t2 |=> id_reg == user_code;
  endproperty
  a_user_cap: assert property (p_user_cap) else $error("user code not loaded");

  property p_user_dflt;
    @(posedge i_tck) disable iff (rst_t2) cap_dr && ir == `IR_USERCODE && !cfg_t2
      |=> id_reg == `USER_CODE_DEFAULT;
  endproperty
  a_user_dflt: assert property (p_user_dflt) else $error("default signature missing");

  property p_clamp_pins;
    @(posedge i_mclk) disable iff (i_sys_rst) clamp_m2 ##1 clamp_m2 |=> o_pin_out == $past(bsr_hold);
  endproperty
  a_clamp_pins: assert property (p_clamp_pins) else $error("pins not held from boundary register");

  property p_clamp_path;
    @(posedge i_tck) disable iff (rst_t2) sh_dr && clamp_on |-> o_tdo == bypass;
  endproperty
  a_clamp_path: assert property (p_clamp_path) else $error("bypass not on serial path");

  property p_lsb_shift;
    @(posedge i_tck) disable iff (rst_t2) sh_dr && id_sel
      |=> id_reg[`ID_LEN-1] == $past(i_tdi) && id_reg[`ID_LEN-2:0] == $past(id_reg[`ID_LEN-1:1]);
  endproperty
  a_lsb_shift: assert property (p_lsb_shift) else $error("shift not lsb first");

  c_id_read:   cover property (@(posedge i_tck) cap_dr && ir == `IR_IDCODE ##1 sh_dr);
  c_user_read: cover property (@(posedge i_tck) cap_dr && ir == `IR_USERCODE && cfg_t2);
  c_clamp:     cover property (@(posedge i_mclk) clamp_m2 && !$past(clamp_m2));
endmodule // scan_id_path
`default_nettype wire

// *** tb/scan_controller.sv ***
// Purpose: behavioural model of the external scan controller driving the test link
// Assumes: link clock period 80 ns, idle low between frames
// Notes:   tdo is sampled just before each rising link clock edge
`timescale 1ns/10ps
`default_nettype none
module scan_controller (
  // link
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #40;
    tdo = i_tdo;
    o_tck = 1'b1;
    #40;
    o_tck = 1'b0;
  endtask

  // data line is not meaningful outside a shift, so it toggles rather than holding
  task automatic walk(input logic tms);
    logic d;
    tick(tms, ~o_tdi, d);
  endtask

  task automatic reset_tap;
    #7;
    repeat (5) walk(1'b1);
    walk(1'b0);
  endtask

  task automatic scan_ir(input logic [3:0] code, output logic [3:0] cap);
    logic d;
    #7;
    walk(1'b1);
    walk(1'b1);
    walk(1'b0);
    walk(1'b0);
    for (int i = 0; i < 4; i++) begin
      tick(i == 3, code[i], d);
      cap[i] = d;
    end
    walk(1'b1);
    walk(1'b0);
  endtask

  task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic d;
    dout = 32'h0;
    #7;
    walk(1'b1);
    walk(1'b0);
    walk(1'b0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], d);
      dout[i] = d;
    end
    walk(1'b1);
    walk(1'b0);
  endtask
endmodule // scan_controller
`default_nettype wire

// *** tb/boundary_scan_id_clamp_instructions_tb.sv ***
// Purpose: self-checking bench for the identity, signature and clamp scan path
// Assumes: controller model drives the link clock only during frames
// Notes:   design inputs change on the falling system clock edge
`include "scan_id_map.svh"
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_id_clamp_instructions_tb;
  logic        mclk;
  logic        sys_rst;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic        tdo_line;
  int          oe_cycles = 0;
  logic        config_done;
  logic [31:0] user_code;
  logic [7:0]  core_out;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  int          fail_count;
  int          n_checks;

  scan_id_path dut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_config_done(config_done), .i_user_code(user_code),
    .i_core_out(core_out), .i_pin_in(pin_in), .o_pin_out(pin_out));
  scan_controller ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_line));

  // the serial out line is pulled up, so a dropped drive enable reads as ones
  assign tdo_line = tdo_oe ? tdo : 1'b1;

  always @(posedge tck) begin
    if (tdo_oe === 1'b1) begin
      oe_cycles++;
    end
  end

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_idcode;
    logic [3:0]  c;
    logic [31:0] d;
    int          n0;
    ctl.reset_tap();
    n0 = oe_cycles;
    ctl.scan_dr(32, 32'h0, d);
    check("idcode after reset", `ID_VALUE, d);
    check("drive enable cycles", 32'd32, oe_cycles - n0);
    check("drive enable idle", 32'h0, {31'h0, tdo_oe});
    ctl.scan_ir(`IR_IDCODE, c);
    check("ir capture", 32'h1, {28'h0, c});
    ctl.scan_dr(32, 32'hFFFF_FFFF, d);
    check("idcode loaded", `ID_VALUE, d);
    $display("test idcode done");
  endtask

  task automatic t_signature;
    logic [3:0]  c;
    logic [31:0] d;
    ctl.scan_ir(`IR_USERCODE, c);
    ctl.scan_dr(32, 32'h0, d);
    check("signature default", `USER_CODE_DEFAULT, d);
    @(negedge mclk);
    user_code = 32'h1357_9BDF;
    config_done = 1'b1;
    @(negedge mclk);
    config_done = 1'b0;
    repeat (2) @(negedge mclk);
    ctl.scan_ir(`IR_USERCODE, c);
    ctl.scan_dr(32, 32'h0, d);
    check("signature configured", 32'h1357_9BDF, d);
    @(negedge mclk);
    user_code = 32'h0;
    ctl.scan_dr(32, 32'h0, d);
    check("signature held", 32'h1357_9BDF, d);
    $display("test signature done");
  endtask

  task automatic t_clamp;
    logic [3:0]  c;
    logic [31:0] d;
    @(negedge mclk);
    core_out = 8'h0F;
    pin_in = 8'h3C;
    ctl.scan_ir(`IR_SAMPLE, c);
    ctl.scan_dr(8, 32'hA5, d);
    check("sampled pins", 32'h3C, d);
    repeat (4) @(negedge mclk);
    check("pins functional", 32'h0F, {24'h0, pin_out});
    ctl.scan_ir(`IR_CLAMP, c);
    repeat (6) @(negedge mclk);
    core_out = 8'hF0;
    repeat (4) @(negedge mclk);
    check("pins clamped", 32'hA5, {24'h0, pin_out});
    // bypass captures 0, then echoes tdi one clock late
    ctl.scan_dr(4, 32'hB, d);
    check("bypass path", 32'h6, d);
    ctl.reset_tap();
    ctl.scan_dr(32, 32'h0, d);
    check("idcode after tap reset", `ID_VALUE, d);
    repeat (6) @(negedge mclk);
    check("pins released", 32'hF0, {24'h0, pin_out});
    $display("test clamp done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    config_done = 1'b0;
    user_code = 32'h0;
    core_out = 8'h0;
    pin_in = 8'h0;
    fail_count = 0;
    n_checks = 0;
    // the link side needs its own clock edges to see reset
    fork
      repeat (4) ctl.walk(1'b1);
      repeat (8) @(negedge mclk);
    join
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
    t_idcode();
    t_signature();
    t_clamp();
    summarize();
  end

  initial begin
    #2000000;
    $display("watchdog expired");
    fail_count++;
    summarize();
  end
endmodule // boundary_scan_id_clamp_instructions_tb
`default_nettype wire
